// [phy_mode_mdix_pkg.sv]
/*
 * constants, field positions and carrier structs for the phy mode and
 * crossover register group.
 * assumes a single 10 MHz clock and a management engine on the same clock.
 */
//
// Operation
// - expansion bit 4 latches parallel detection fault
// - expansion bit 1 latches new page received
// - expansion bit 2 reads 0, no next page
// - bits 0 and 3 show partner abilities
// - mode control bit 13 enables energy powerdown
// - energy_present drops after 256 ms quiet
// - energy_present set by hardware reset or line energy
// - special modes bits 7:5 hold operating mode
// - bits 4:0 hold management address, default 00001
// - modes 000/001 give 10 half/full, no autoneg
// - modes 010/011 give 100 half/full, no autoneg
// - mode 100 autoneg, advertise 100 half only
// - mode 101 repeater, carrier sense on receive
// - mode 111 advertises all, follows negotiated result
// - bit 15 picks strap pin or register bits
// - bit 14 selects automatic or manual crossover
// - manual bit 13 swaps transmit and receive pairs
// - bit 10 forces 10M receive pll to reference
// - bit 4 reports 10BASE-T receive polarity reversed
// - bits 3:0 read-only, writes ignored
// - parallel fault also latches interrupt source bit 2
package phy_mode_mdix_pkg;

	// ==========================================================
	// register indexes
	// ==========================================================
	localparam logic [4:0] IDX_EXPANSION    = 5'h06;   // autoneg_expansion_status
	localparam logic [4:0] IDX_ENERGY       = 5'h11;   // energy_mode_control
	localparam logic [4:0] IDX_OPMODE       = 5'h12;   // operating_mode_address
	localparam logic [4:0] IDX_CROSSOVER    = 5'h1b;   // crossover_polarity_control
	localparam logic [4:0] IDX_INT_SOURCE   = 5'h1d;   // interrupt source, read clears

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int EXP_LP_AN_ABLE   = 0;
	localparam int EXP_PAGE_RCVD    = 1;
	localparam int EXP_NP_ABLE      = 2;
	localparam int EXP_LP_NP_ABLE   = 3;
	localparam int EXP_PAR_FAULT    = 4;
	localparam int ENG_PRESENT      = 1;
	localparam int ENG_PWRDN_EN     = 13;
	localparam int OPM_ADDR_LSB     = 0;
	localparam int OPM_MODE_LSB     = 5;
	localparam int OPM_RSVD_LSB     = 8;
	localparam int XO_POL_REV       = 4;
	localparam int XO_PLL_FORCE     = 10;
	localparam int XO_MANUAL_SWAP   = 13;
	localparam int XO_AUTO_EN       = 14;
	localparam int XO_OVERRIDE      = 15;

	// ==========================================================
	// reset values and modes
	// ==========================================================
	localparam logic [15:0] ZERO16        = 16'h0000;
	localparam logic [4:0]  ADDR_DEFAULT  = 5'h01;
	localparam logic [7:0]  RSVD_DEFAULT  = 8'h00;
	localparam logic [2:0]  MODE_10_HD    = 3'h0;
	localparam logic [2:0]  MODE_10_FD    = 3'h1;
	localparam logic [2:0]  MODE_100_HD   = 3'h2;
	localparam logic [2:0]  MODE_100_FD   = 3'h3;
	localparam logic [2:0]  MODE_AN_100HD = 3'h4;
	localparam logic [2:0]  MODE_REPEATER = 3'h5;
	localparam logic [2:0]  MODE_ALL      = 3'h7;
	localparam logic [2:0]  MODE_DEFAULT  = 3'h7;

	// ==========================================================
	// timing
	// ==========================================================
	localparam longint CLK_HZ          = 64'd10000000;
	localparam longint ENERGY_QUIET_MS = 64'd256;
	// longest time rounds down
	localparam int ENERGY_QUIET_CYC = int'((ENERGY_QUIET_MS * CLK_HZ) / 64'd1000);
	localparam int QUIET_CNT_W      = 22;

	// ==========================================================
	// carriers
	// ==========================================================
	// line-side inputs, all asynchronous to mclk_i
	typedef struct packed {
		logic energy_detect;    // valid energy seen on the pair
		logic par_fault;        // parallel detection fault
		logic page_rcvd;        // new autoneg page arrived
		logic lp_an_able;       // partner can autonegotiate
		logic lp_np_able;       // partner can exchange next pages
		logic polarity_rev;     // 10BASE-T receive polarity reversed
		logic auto_strap;       // crossover_auto_strap_pin level
		logic nego_speed100;    // negotiated speed is 100
		logic nego_full;        // negotiated duplex is full
	} line_in_s;

	// basic-control bits 13,12,10,8 and advertisement bits 8,7,6,5
	typedef struct packed {
		logic speed100;
		logic an_enable;
		logic isolate;
		logic full_duplex;
	} ctrl_bits_s;

	typedef struct packed {
		logic tx_fd;
		logic tx_hd;
		logic t10_fd;
		logic t10_hd;
	} adv_bits_s;

	// decoded mode outputs
	typedef struct packed {
		ctrl_bits_s ctrl;
		adv_bits_s  adv;
		logic       adv_valid;    // advertisement bits forced by mode
		logic       crs_on_tx;    // carrier sense also during transmit
		logic       repeater;     // repeater mode active
	} mode_out_s;

	// management request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  phy_addr;
		logic [4:0]  reg_idx;
		logic [15:0] wdata;
	} mgmt_req_s;

endpackage

// [line_sync.sv]
/*
 * two flip-flop synchroniser bank for line-side levels.
 * assumes each input level stays stable for at least two clock periods.
 */
`timescale 1ns/1ns
module line_sync
#(
	parameter int WIDTH = 9
)
(
	input  wire logic             mclk_i,    // block clock
	input  wire logic             rst_i,     // synchronous reset
	input  wire logic [WIDTH-1:0] async_i,   // raw line levels
	output logic      [WIDTH-1:0] sync_o     // levels after two flops
);

	// ==========================================================
	// state
	// ==========================================================
	typedef struct packed {
		logic [WIDTH-1:0] first;    // read only by second stage
		logic [WIDTH-1:0] second;   // safe to use
	} sync_state_s;

	sync_state_s state_ff;      // registered state
	sync_state_s nxt_state;     // next state

	// next-state logic
	always_comb
	begin
		nxt_state        = state_ff;
		nxt_state.first  = async_i;
		nxt_state.second = state_ff.first;
		if (rst_i)
		begin
			nxt_state = '0;
		end
	end

	// state register
	always_ff @(posedge mclk_i)
	begin
		state_ff <= nxt_state;
	end

	assign sync_o = state_ff.second;

endmodule

// [phy_mode_mdix_regs.sv]
/*
 * management-reachable phy register group: autoneg expansion, energy
 * powerdown control, operating mode and address, crossover control.
 * assumes a management engine on mclk_i that issues one-cycle read and
 * write strobes with phy and register address; line levels arrive
 * asynchronously and are synchronised here.
 */
`timescale 1ns/1ns
module phy_mode_mdix_regs
#(
	parameter int ENERGY_QUIET_CYCLES = phy_mode_mdix_pkg::ENERGY_QUIET_CYC
)
(
	input  wire logic                         mclk_i,              // 10 MHz clock
	input  wire logic                         rst_i,               // hardware reset
	input  wire logic                         soft_rst_i,          // software reset pulse
	input  wire phy_mode_mdix_pkg::mgmt_req_s mgmt_req_i,          // management request
	output logic [15:0]                       mgmt_rdata_o,        // read data
	output logic                              mgmt_rvalid_o,       // read data valid pulse
	input  wire phy_mode_mdix_pkg::line_in_s  line_i,              // raw line levels
	output phy_mode_mdix_pkg::mode_out_s      mode_o,              // decoded mode
	output logic [4:0]                        phy_mgmt_address_o,  // answering address
	output logic                              energy_pwrdn_en_o,   // powerdown enable
	output logic                              energy_present_o,    // line energy status
	output logic                              crossover_auto_o,    // automatic crossover on
	output logic                              pair_swap_o,         // tx_pair/rx_pair swapped
	output logic                              rx_pll_force_ref_o,  // 10M pll on reference
	output logic                              par_fault_int_o      // interrupt source bit 2
);

	// ==========================================================
	// synchronised line inputs
	// ==========================================================
	phy_mode_mdix_pkg::line_in_s line_sync_w;   // line levels after two flops

	line_sync #(
		.WIDTH ($bits(phy_mode_mdix_pkg::line_in_s))
	) u_line_sync (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.async_i(line_i),
		.sync_o (line_sync_w)
	);

	// ==========================================================
	// state
	// ==========================================================
	typedef struct packed {
		logic        par_fault_lh;     // latched fault flag
		logic        page_rcvd_lh;     // latched page flag
		logic        par_fault_int;    // interrupt source copy of fault
		logic        pwrdn_en;         // energy powerdown enable
		logic        energy_present;   // live energy status
		logic [phy_mode_mdix_pkg::QUIET_CNT_W-1:0] quiet_cnt;  // quiet cycles
		logic [7:0]  opm_rsvd;         // reserved bits 15:8, retained
		logic [2:0]  op_mode;          // operating mode, retained
		logic [4:0]  phy_addr;         // management address, retained
		logic        xo_override;      // use register not strap
		logic        xo_auto_en;       // automatic crossover
		logic        xo_manual_swap;   // manual swap
		logic        pll_force_ref;    // pll force, retained
		logic [15:0] rdata;            // read data
		logic        rvalid;           // read data valid
	} regs_state_s;

	regs_state_s state_ff;   // registered state
	regs_state_s nxt_state;  // next state

	// ==========================================================
	// helpers
	// ==========================================================
	// latching-high flag: set wins over the read that clears it
	function automatic logic latch_high(input logic held, input logic clr, input logic ev);
		latch_high = (held & ~clr) | ev;
	endfunction

	// request addresses this phy at the given register index
	function automatic logic hit(input phy_mode_mdix_pkg::mgmt_req_s req,
	                             input logic [4:0] addr, input logic [4:0] idx);
		hit = (req.phy_addr == addr) && (req.reg_idx == idx);
	endfunction

	// ==========================================================
	// read data views
	// ==========================================================
	logic [15:0] exp_view;   // expansion register value
	logic [15:0] eng_view;   // mode control value
	logic [15:0] opm_view;   // special modes value
	logic [15:0] xo_view;    // crossover register value

	// build read views from current state
	always_comb
	begin
		exp_view = phy_mode_mdix_pkg::ZERO16;
		exp_view[phy_mode_mdix_pkg::EXP_PAR_FAULT]  = state_ff.par_fault_lh | line_sync_w.par_fault;
		exp_view[phy_mode_mdix_pkg::EXP_LP_NP_ABLE] = line_sync_w.lp_np_able;
		exp_view[phy_mode_mdix_pkg::EXP_NP_ABLE]    = 1'b0;
		exp_view[phy_mode_mdix_pkg::EXP_PAGE_RCVD]  = state_ff.page_rcvd_lh | line_sync_w.page_rcvd;
		exp_view[phy_mode_mdix_pkg::EXP_LP_AN_ABLE] = line_sync_w.lp_an_able;

		eng_view = phy_mode_mdix_pkg::ZERO16;
		eng_view[phy_mode_mdix_pkg::ENG_PWRDN_EN] = state_ff.pwrdn_en;
		eng_view[phy_mode_mdix_pkg::ENG_PRESENT]  = state_ff.energy_present;

		opm_view = phy_mode_mdix_pkg::ZERO16;
		opm_view[phy_mode_mdix_pkg::OPM_RSVD_LSB +: 8] = state_ff.opm_rsvd;
		opm_view[phy_mode_mdix_pkg::OPM_MODE_LSB +: 3] = state_ff.op_mode;
		opm_view[phy_mode_mdix_pkg::OPM_ADDR_LSB +: 5] = state_ff.phy_addr;

		// bits 3:0 have no defined value; this block returns zero there
		xo_view = phy_mode_mdix_pkg::ZERO16;
		xo_view[phy_mode_mdix_pkg::XO_OVERRIDE]    = state_ff.xo_override;
		xo_view[phy_mode_mdix_pkg::XO_AUTO_EN]     = state_ff.xo_auto_en;
		xo_view[phy_mode_mdix_pkg::XO_MANUAL_SWAP] = state_ff.xo_manual_swap;
		xo_view[phy_mode_mdix_pkg::XO_PLL_FORCE]   = state_ff.pll_force_ref;
		xo_view[phy_mode_mdix_pkg::XO_POL_REV]     = line_sync_w.polarity_rev;
	end

	// ==========================================================
	// next-state logic
	// ==========================================================
	logic rd_exp;    // read of expansion register
	logic rd_int;    // read of interrupt source register
	logic wr_eng;    // write of mode control
	logic wr_opm;    // write of special modes
	logic wr_xo;     // write of crossover register

	always_comb
	begin
		rd_exp = mgmt_req_i.rd & hit(mgmt_req_i, state_ff.phy_addr, phy_mode_mdix_pkg::IDX_EXPANSION);
		rd_int = mgmt_req_i.rd & hit(mgmt_req_i, state_ff.phy_addr, phy_mode_mdix_pkg::IDX_INT_SOURCE);
		wr_eng = mgmt_req_i.wr & hit(mgmt_req_i, state_ff.phy_addr, phy_mode_mdix_pkg::IDX_ENERGY);
		wr_opm = mgmt_req_i.wr & hit(mgmt_req_i, state_ff.phy_addr, phy_mode_mdix_pkg::IDX_OPMODE);
		wr_xo  = mgmt_req_i.wr & hit(mgmt_req_i, state_ff.phy_addr, phy_mode_mdix_pkg::IDX_CROSSOVER);

		nxt_state        = state_ff;
		nxt_state.rvalid = 1'b0;

		// latched flags, cleared by a read of their register (the interrupt source read gets no answer)
		nxt_state.par_fault_lh  = latch_high(state_ff.par_fault_lh, rd_exp,
		                                     line_sync_w.par_fault);
		nxt_state.page_rcvd_lh  = latch_high(state_ff.page_rcvd_lh, rd_exp,
		                                     line_sync_w.page_rcvd);
		nxt_state.par_fault_int = latch_high(state_ff.par_fault_int, rd_int,
		                                     line_sync_w.par_fault);

		// energy present: set on energy, clear after a quiet spell
		if (line_sync_w.energy_detect)
		begin
			nxt_state.quiet_cnt      = '0;
			nxt_state.energy_present = 1'b1;
		end
		else if (32'(state_ff.quiet_cnt) >= ENERGY_QUIET_CYCLES - 1)
		begin
			nxt_state.energy_present = 1'b0;
		end
		else
		begin
			nxt_state.quiet_cnt = state_ff.quiet_cnt + 1'b1;
		end

		// management writes
		if (wr_eng)
		begin
			nxt_state.pwrdn_en = mgmt_req_i.wdata[phy_mode_mdix_pkg::ENG_PWRDN_EN];
		end
		if (wr_opm)
		begin
			nxt_state.opm_rsvd = mgmt_req_i.wdata[phy_mode_mdix_pkg::OPM_RSVD_LSB +: 8];
			nxt_state.op_mode  = mgmt_req_i.wdata[phy_mode_mdix_pkg::OPM_MODE_LSB +: 3];
			nxt_state.phy_addr = mgmt_req_i.wdata[phy_mode_mdix_pkg::OPM_ADDR_LSB +: 5];
		end
		if (wr_xo)
		begin
			// bits 3:0 and 4 are not stored, so writes there do nothing
			nxt_state.xo_override    = mgmt_req_i.wdata[phy_mode_mdix_pkg::XO_OVERRIDE];
			nxt_state.xo_auto_en     = mgmt_req_i.wdata[phy_mode_mdix_pkg::XO_AUTO_EN];
			nxt_state.xo_manual_swap = mgmt_req_i.wdata[phy_mode_mdix_pkg::XO_MANUAL_SWAP];
			nxt_state.pll_force_ref  = mgmt_req_i.wdata[phy_mode_mdix_pkg::XO_PLL_FORCE];
		end

		// read mux; unknown indexes belong to other blocks and get no answer
		if (mgmt_req_i.rd && (mgmt_req_i.phy_addr == state_ff.phy_addr))
		begin
			case (mgmt_req_i.reg_idx)
				phy_mode_mdix_pkg::IDX_EXPANSION:
				begin
					nxt_state.rdata  = exp_view;
					nxt_state.rvalid = 1'b1;
				end
				phy_mode_mdix_pkg::IDX_ENERGY:
				begin
					nxt_state.rdata  = eng_view;
					nxt_state.rvalid = 1'b1;
				end
				phy_mode_mdix_pkg::IDX_OPMODE:
				begin
					nxt_state.rdata  = opm_view;
					nxt_state.rvalid = 1'b1;
				end
				phy_mode_mdix_pkg::IDX_CROSSOVER:
				begin
					nxt_state.rdata  = xo_view;
					nxt_state.rvalid = 1'b1;
				end
				default:
				begin
					nxt_state.rvalid = 1'b0;
				end
			endcase
		end

		// software reset: retained fields and energy status untouched
		if (soft_rst_i)
		begin
			nxt_state.par_fault_lh   = 1'b0;
			nxt_state.page_rcvd_lh   = 1'b0;
			nxt_state.par_fault_int  = 1'b0;
			nxt_state.pwrdn_en       = 1'b0;
			nxt_state.xo_override    = 1'b0;
			nxt_state.xo_auto_en     = 1'b0;
			nxt_state.xo_manual_swap = 1'b0;
			nxt_state.rvalid         = 1'b0;
		end

		// hardware reset: everything to defaults, energy reads 1
		if (rst_i)
		begin
			nxt_state                = '0;
			nxt_state.energy_present = 1'b1;
			nxt_state.opm_rsvd       = phy_mode_mdix_pkg::RSVD_DEFAULT;
			nxt_state.op_mode        = phy_mode_mdix_pkg::MODE_DEFAULT;
			nxt_state.phy_addr       = phy_mode_mdix_pkg::ADDR_DEFAULT;
		end
	end

	// state register
	always_ff @(posedge mclk_i)
	begin
		state_ff <= nxt_state;
	end

	// ==========================================================
	// mode decode
	// ==========================================================
	phy_mode_mdix_pkg::mode_out_s mode_dec;   // decoded mode

	// operating mode to control, advertisement and carrier sense
	always_comb
	begin
		mode_dec = '0;
		case (state_ff.op_mode)
			phy_mode_mdix_pkg::MODE_10_HD:
			begin
				mode_dec.ctrl      = 4'b0000;
				mode_dec.crs_on_tx = 1'b1;
			end
			phy_mode_mdix_pkg::MODE_10_FD:
			begin
				mode_dec.ctrl = 4'b0001;
			end
			phy_mode_mdix_pkg::MODE_100_HD:
			begin
				mode_dec.ctrl      = 4'b1000;
				mode_dec.crs_on_tx = 1'b1;
			end
			phy_mode_mdix_pkg::MODE_100_FD:
			begin
				mode_dec.ctrl = 4'b1001;
			end
			phy_mode_mdix_pkg::MODE_AN_100HD:
			begin
				mode_dec.ctrl      = 4'b1100;
				mode_dec.adv       = 4'b0100;
				mode_dec.adv_valid = 1'b1;
				mode_dec.crs_on_tx = 1'b1;
			end
			phy_mode_mdix_pkg::MODE_REPEATER:
			begin
				mode_dec.ctrl      = 4'b1100;
				mode_dec.adv       = 4'b0100;
				mode_dec.adv_valid = 1'b1;
				mode_dec.repeater  = 1'b1;
			end
			phy_mode_mdix_pkg::MODE_ALL:
			begin
				mode_dec.ctrl.speed100    = line_sync_w.nego_speed100;
				mode_dec.ctrl.an_enable   = 1'b1;
				mode_dec.ctrl.isolate     = 1'b0;
				mode_dec.ctrl.full_duplex = line_sync_w.nego_full;
				mode_dec.adv              = 4'b1111;
				mode_dec.adv_valid        = 1'b1;
				mode_dec.crs_on_tx        = ~line_sync_w.nego_full;
			end
			default:
			begin
				// reserved mode: software keeps away, outputs stay quiet
				mode_dec = '0;
			end
		endcase
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign mode_o             = mode_dec;
	assign mgmt_rdata_o       = state_ff.rdata;
	assign mgmt_rvalid_o      = state_ff.rvalid;
	assign phy_mgmt_address_o = state_ff.phy_addr;
	assign energy_pwrdn_en_o  = state_ff.pwrdn_en;
	assign energy_present_o   = state_ff.energy_present;
	assign rx_pll_force_ref_o = state_ff.pll_force_ref;
	assign par_fault_int_o    = state_ff.par_fault_int;
	// strap or register decides crossover; bit 13 ignored while automatic
	assign crossover_auto_o   = state_ff.xo_override ? state_ff.xo_auto_en
	                                                 : line_sync_w.auto_strap;
	assign pair_swap_o        = state_ff.xo_override & ~state_ff.xo_auto_en
	                            & state_ff.xo_manual_swap;

endmodule

// [link_partner.sv]
/* far-side line partner: presents the levels the bench asks for.
   assumes the bench changes its request away from the sampling edge */
`timescale 1ns/1ns
module link_partner
(
	input  wire logic [8:0]                  want_i,   // requested line levels
	output phy_mode_mdix_pkg::line_in_s      line_o    // levels seen by the block
);
	// partner abilities, polarity and strap come straight from the request
	assign line_o = want_i;
endmodule

// [phy_mode_mdix_regs_chk.sv]
/* concurrent checks on the register group ports.
   assumes it is bound onto phy_mode_mdix_regs with matching port names */
`timescale 1ns/1ns
module phy_mode_mdix_regs_chk
(
	input wire logic                         mclk_i,
	input wire logic                         rst_i,
	input wire logic                         soft_rst_i,
	input wire phy_mode_mdix_pkg::mgmt_req_s mgmt_req_i,
	input wire logic                         mgmt_rvalid_o,
	input wire phy_mode_mdix_pkg::line_in_s  line_i,
	input wire phy_mode_mdix_pkg::mode_out_s mode_o,
	input wire logic [4:0]                   phy_mgmt_address_o,
	input wire logic                         energy_pwrdn_en_o,
	input wire logic                         energy_present_o,
	input wire logic                         crossover_auto_o,
	input wire logic                         pair_swap_o,
	input wire logic                         par_fault_int_o
);
	logic hit;   // request aimed at this phy
	logic take;  // read that must be answered
	assign hit = mgmt_req_i.phy_addr == phy_mgmt_address_o;
	assign take = mgmt_req_i.rd && hit && !soft_rst_i
		&& (mgmt_req_i.reg_idx inside {5'h06, 5'h11, 5'h12, 5'h1b});
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// assertions
	// ==========================================================
	read_answer_a: assert property (take |=> mgmt_rvalid_o)
		else $error("mapped read got no answer");
	foreign_addr_a: assert property (mgmt_req_i.rd && !hit |=> !mgmt_rvalid_o)
		else $error("read for another address answered");
	an_adv_a: assert property (mode_o.ctrl.an_enable == mode_o.adv_valid)
		else $error("autoneg and advertisement disagree");
	adv_code_a: assert property (mode_o.adv_valid |-> mode_o.adv inside {4'h4, 4'hf})
		else $error("bad advertisement pattern");
	repeater_crs_a: assert property (mode_o.repeater |-> !mode_o.crs_on_tx)
		else $error("repeater senses carrier on transmit");
	swap_manual_a: assert property (pair_swap_o |-> !crossover_auto_o)
		else $error("pairs swapped while crossover automatic");
	hw_energy_a: assert property ($fell(rst_i) |-> energy_present_o)
		else $error("energy status low after hardware reset");
	soft_keep_a: assert property (soft_rst_i && !mgmt_req_i.wr
		|=> $stable(phy_mgmt_address_o) && !energy_pwrdn_en_o) else $error("soft reset mishandled");
	energy_on_a: assert property (line_i.energy_detect [*4] |=> energy_present_o)
		else $error("energy status missed line energy");
	fault_hold_a: assert property (par_fault_int_o && !soft_rst_i
		&& !(mgmt_req_i.rd && hit && mgmt_req_i.reg_idx == 5'h1d) |=> par_fault_int_o)
		else $error("fault flag lost before its read");
endmodule
bind phy_mode_mdix_regs phy_mode_mdix_regs_chk chk (.*);

// [tb_top.sv]
/* self-checking bench for the phy register group, with a line partner.
   assumes package, design, checker and partner are compiled first */
`timescale 1ns/1ns
module tb_top;
	logic                         mclk_i = 1'b0, rst_i = 1'b1, soft_rst_i = 1'b0;
	phy_mode_mdix_pkg::mgmt_req_s mgmt_req_i = '0;  // management request
	phy_mode_mdix_pkg::line_in_s  line_i;           // partner levels
	phy_mode_mdix_pkg::mode_out_s mode_o;           // decoded mode
	logic [15:0]                  mgmt_rdata_o, d;
	logic [4:0]                   phy_mgmt_address_o;
	logic                         mgmt_rvalid_o, energy_pwrdn_en_o, energy_present_o, pair_swap_o;
	logic                         crossover_auto_o, rx_pll_force_ref_o, par_fault_int_o;
	logic [8:0]                   want = 9'h100;          // levels asked of the partner
	logic [31:0]                  seed = 32'h0000_37d5, v; // xorshift state
	logic [16:0]                  a;                       // answer: valid and data
	int                           fails = 0, n_tests = 0;
	int m_mode = 7, m_addr = 1, m_hi = 0, m_xo = 0, m_pwr = 0, m_en = 1, m_lat = 0; // model
	localparam logic [4:0]        IDX [4] = '{5'h06, 5'h11, 5'h12, 5'h1b};
	phy_mode_mdix_regs #(.ENERGY_QUIET_CYCLES(20)) dut (.*);
	link_partner partner (.want_i(want), .line_o(line_i));
	initial
	begin
		forever #50 mclk_i = ~mclk_i;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected read view from the model
	function automatic logic [15:0] view(input logic [4:0] idx);
		case (idx)
			5'h06: view = {11'h0, want[7] | m_lat[4], want[4], 1'b0, want[6] | m_lat[1], want[5]};
			5'h11: view = {2'h0, m_pwr[0], 11'h0, m_en[0], 1'b0};
			5'h12: view = {m_hi[7:0], m_mode[2:0], m_addr[4:0]};
			default: view = m_xo[15:0] | {11'h0, want[3], 4'h0};
		endcase
	endfunction
	// expected mode decode: ctrl, adv, adv_valid, crs_on_tx, repeater
	function automatic logic [10:0] mexp(input int m);
		case (m)
			0: mexp = 11'h002;
			1: mexp = 11'h080;
			2: mexp = 11'h402;
			3: mexp = 11'h480;
			4: mexp = 11'h626;
			5: mexp = 11'h625;
			default: mexp = {want[1], 2'b10, want[0], 4'hf, 1'b1, !want[0], 1'b0};
		endcase
	endfunction
	task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one management access: strobe one cycle, take the answer, then idle one cycle
	task automatic req(input logic r, input logic [4:0] pa, input logic [4:0] idx,
		input logic [15:0] w, output logic [16:0] ans);
		mgmt_req_i = '{r, !r, pa, idx, w};
		@(negedge mclk_i);
		ans = {mgmt_rvalid_o, mgmt_rdata_o};
		mgmt_req_i = '0;
		@(negedge mclk_i);
	endtask
	task automatic rd(input logic [4:0] idx, input logic [15:0] e);
		logic [16:0] r;
		req(1'b1, m_addr[4:0], idx, 16'h0000, r);
		chk(r, {1'b1, e});
		if (idx == 5'h06)
			m_lat = 0;
	endtask
	task automatic wr(input logic [4:0] idx, input logic [15:0] w);
		logic [16:0] r;
		req(1'b0, m_addr[4:0], idx, w, r);
		chk({16'h0, r[16]}, 17'h0_0000);
	endtask
	task automatic rd_all();
		foreach (IDX[i])
			rd(IDX[i], view(IDX[i]));
	endtask
	// main sequence
	initial
	begin
		repeat (16) @(negedge mclk_i);
		rst_i = 1'b0;
		rd_all();
		for (int i = 0; i < 8; i++)
		begin
			if (i == 6)
				continue; // reserved mode is never programmed
			v = xs();
			d = v[31:16];
			d[13] = d[13] & !d[14]; // bit 13 stays clear with automatic crossover
			want = {3'b100, v[5:0]};
			wr(5'h12, {v[15:8], i[2:0], v[20:16]});
			{m_hi, m_mode, m_addr} = {int'(v[15:8]), i, int'(v[20:16])};
			wr(5'h1b, d);
			m_xo = d & 16'he400;
			req(1'b1, m_addr[4:0] ^ 5'h01, 5'h06, 16'h0000, a);
			chk({16'h0, a[16]}, 17'h0_0000);
			rd(5'h12, view(5'h12));
			rd(5'h1b, view(5'h1b));
			rd(5'h06, view(5'h06));
			chk({6'h0, mode_o}, {6'h0, mexp(i)});
			chk({12'h0, phy_mgmt_address_o}, {12'h0, m_addr[4:0]});
			chk({14'h0, crossover_auto_o, pair_swap_o, rx_pll_force_ref_o},
				{14'h0, d[15] ? d[14] : want[2], d[15] & !d[14] & d[13], d[10]});
		end
		want = 9'h1c0;
		repeat (3) @(negedge mclk_i);
		want = 9'h100;
		m_lat = 16'h0012;
		repeat (3) @(negedge mclk_i);
		chk({16'h0, par_fault_int_o}, 17'h0_0001);
		rd(5'h06, view(5'h06));
		rd(5'h06, view(5'h06));
		req(1'b1, m_addr[4:0], 5'h1d, 16'h0000, a);
		chk({15'h0, a[16], par_fault_int_o}, 17'h0_0000);
		want = 9'h000;
		repeat (12) @(negedge mclk_i);
		rd(5'h11, view(5'h11));
		repeat (16) @(negedge mclk_i);
		m_en = 0;
		rd(5'h11, view(5'h11));
		wr(5'h11, 16'hffff);
		m_pwr = 1;
		rd(5'h11, view(5'h11));
		chk({15'h0, energy_pwrdn_en_o, energy_present_o}, {15'h0, m_pwr[0], m_en[0]});
		soft_rst_i = 1'b1;
		@(negedge mclk_i);
		soft_rst_i = 1'b0;
		m_pwr = 0;
		m_xo = m_xo & 16'h0400;
		rd_all();
		rst_i = 1'b1;
		repeat (3) @(negedge mclk_i);
		rst_i = 1'b0;
		m_mode = 7;
		m_addr = 1;
		m_hi = 0;
		m_xo = 0;
		m_en = 1;
		rd_all();
		chk({15'h0, energy_pwrdn_en_o, energy_present_o}, {15'h0, m_pwr[0], m_en[0]});
		report_and_stop();
	end
endmodule
